// ==== pkg/bsd_pkg.sv ====
// Constants and types shared by the bridge switch drive control block
package bsd_pkg;

    // Clocking and timebase
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_HZ = 1_000_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam logic [4:0] OSC_LAST = 5'(OSC_DIV - 1);
    localparam int RATE_SLOW_HZ = 1;
    localparam int RATE_MID_HZ = 4;
    localparam int RATE_FAST_HZ = 1000;
    localparam int HALF_SLOW = OSC_HZ / (2 * RATE_SLOW_HZ);
    localparam int HALF_MID = OSC_HZ / (2 * RATE_MID_HZ);
    localparam int HALF_FAST = OSC_HZ / (2 * RATE_FAST_HZ);
    localparam int CNT_W = 20;

    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_IRQ_STAT = 5'h08;
    localparam logic [4:0] REG_IRQ_CLR = 5'h0c;
    localparam logic [4:0] REG_IRQ_EN = 5'h10;

    // Control fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_CLR_BIT = 2;
    localparam logic [1:0] CTRL_SEL_RST = 2'h1;

    // Status fields
    localparam int ST_OC_LSB = 0;
    localparam int ST_OV_BIT = 4;
    localparam int ST_PHASE_BIT = 5;
    localparam int ST_GATE_BIT = 6;
    localparam int ST_OCIN_LSB = 7;
    localparam int ST_SEL_LSB = 11;

    // Events: four overcurrent channels plus overvoltage
    localparam int NUM_OC = 4;
    localparam int NUM_EV = 5;
    localparam logic [NUM_EV-1:0] IRQ_EN_RST = 5'h00;

    // Synchroniser lanes and their reset levels
    localparam int SY_W = 8;
    localparam int SY_OV = 4;
    localparam int SY_EXT = 5;
    localparam int SY_DUTY = 6;
    localparam int SY_BTN = 7;
    localparam logic [SY_W-1:0] SY_RST = 8'h0f;

    typedef enum logic [1:0] {
        BSD_SEL_RUN,
        BSD_SEL_SLOW,
        BSD_SEL_MID,
        BSD_SEL_FAST
    } bsd_sel_t;

    typedef struct packed {
        logic a_hi;
        logic a_lo;
        logic b_hi;
        logic b_lo;
    } bsd_drive_t;

    typedef struct packed {
        logic [NUM_OC-1:0] oc;
        logic ov;
    } bsd_fault_t;

endpackage

// ==== hdl/bsd_sync.sv ====
// Two-stage level synchroniser for asynchronous inputs
module bsd_sync
    import bsd_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ==== hdl/bsd_drive_ctrl.sv ====
// Bridge switch drive control: timebase, drive gating, fault latches, bus
// What this block does
// - Internal test timing derived from a 1 MHz oscillator tick, divided down.
// - Test selector gives 1 Hz, 4 Hz and 1 kHz internal drive toggling.
// - Pair A outputs together, in antiphase with pair B outputs.
// - Run position takes drive phase from the external optical drive input.
// - Loss of an overcurrent input light sets that channel's fault latch.
// - Faults hold until reset; overcurrent clears only once input healthy.
// - Separate overvoltage latch with indicator, stays set while cause persists.
// - Each fault indication belongs to one specific protection channel.
// - Drive passes only with no fault latched and duty enable active.
// - Any indicated fault suppresses all drive outputs, any drive source.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
module bsd_drive_ctrl
    import bsd_pkg::*;
#(
    parameter int HALF_SLOW_P = HALF_SLOW,
    parameter int HALF_MID_P = HALF_MID
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic overcurrent_input_1,
    input wire logic overcurrent_input_2,
    input wire logic overcurrent_input_3,
    input wire logic overcurrent_input_4,
    input wire logic overvoltage_input,
    input wire logic ext_drive_input,
    input wire logic duty_enable_input,
    input wire logic fault_reset_button,
    output logic switch_drive_a_hi,
    output logic switch_drive_a_lo,
    output logic switch_drive_b_hi,
    output logic switch_drive_b_lo,
    output logic [NUM_OC-1:0] overcurrent_ind,
    output logic overvoltage_ind,
    output logic irq
);

    function automatic logic [CNT_W-1:0] half_of(input bsd_sel_t s);
        case (s)
            BSD_SEL_SLOW: half_of = CNT_W'(HALF_SLOW_P);
            BSD_SEL_MID: half_of = CNT_W'(HALF_MID_P);
            BSD_SEL_FAST: half_of = CNT_W'(HALF_FAST);
            default: half_of = CNT_W'(HALF_FAST);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [SY_W-1:0] sy;
    logic [NUM_OC-1:0] oc_ok;
    logic ov_sync;
    logic ext_sync;
    logic duty_sync;
    logic btn_sync;

    bsd_sync #(.W(SY_W), .RST_VAL(SY_RST)) u_sync
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({fault_reset_button, duty_enable_input, ext_drive_input,
            overvoltage_input, overcurrent_input_4, overcurrent_input_3,
            overcurrent_input_2, overcurrent_input_1}),
        .sync_out(sy)
    );

    assign oc_ok = sy[NUM_OC-1:0];
    assign ov_sync = sy[SY_OV];
    assign ext_sync = sy[SY_EXT];
    assign duty_sync = sy[SY_DUTY];
    assign btn_sync = sy[SY_BTN];

    ////////////////////////////////////////////////////////////////////////
    // Register bus: one wait state on every access

    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    bsd_sel_t sel_q, sel_d;
    logic [NUM_EV-1:0] irq_en_q, irq_en_d;
    logic [NUM_EV-1:0] irq_st_q, irq_st_d;
    logic sw_clr;
    logic wr_go;
    bsd_fault_t flt_q;
    logic phase_q;
    logic gate_ok;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_go = avs_write & ack_q;
    assign avs_readdata = rdata_q;

    always_comb
    begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        rdata_d = rdata_q;
        sel_d = sel_q;
        irq_en_d = irq_en_q;
        sw_clr = 1'b0;
        if (avs_read & ~ack_q)
        begin
            case (avs_address)
                REG_CTRL: rdata_d = 32'({sel_q});
                REG_STATUS: rdata_d = 32'({sel_q, oc_ok, gate_ok, phase_q,
                    flt_q.ov, flt_q.oc});
                REG_IRQ_STAT: rdata_d = 32'(irq_st_q);
                REG_IRQ_EN: rdata_d = 32'(irq_en_q);
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_go && avs_byteenable[0])
        begin
            case (avs_address)
                REG_CTRL:
                begin
                    sel_d = bsd_sel_t'(avs_writedata[CTRL_SEL_LSB +: 2]);
                    sw_clr = avs_writedata[CTRL_CLR_BIT];
                end
                REG_IRQ_EN: irq_en_d = avs_writedata[NUM_EV-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            sel_q <= bsd_sel_t'(CTRL_SEL_RST);
            irq_en_q <= IRQ_EN_RST;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            sel_q <= sel_d;
            irq_en_q <= irq_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebase: 1 MHz tick and half-period counter

    logic [4:0] osc_q, osc_d;
    logic tick;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic phase_d;
    logic half_end;

    assign tick = (osc_q == OSC_LAST);
    assign half_end = tick && (cnt_q >= half_of(sel_q) - CNT_W'(1));

    always_comb
    begin
        osc_d = tick ? 5'h00 : osc_q + 5'h01;
        cnt_d = cnt_q;
        phase_d = phase_q;
        if (sel_q == BSD_SEL_RUN)
        begin
            cnt_d = '0;
            phase_d = ext_sync;
        end
        else if (half_end)
        begin
            cnt_d = '0;
            phase_d = ~phase_q;
        end
        else if (tick)
        begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_q <= 5'h00;
            cnt_q <= '0;
            phase_q <= 1'b0;
        end
        else
        begin
            osc_q <= osc_d;
            cnt_q <= cnt_d;
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault latches and clear request
    logic btn_prev_q, fault_clr;
    bsd_fault_t flt_d;
    logic [NUM_OC-1:0] oc_lost, oc_ok_prev_q;
    wire logic [NUM_OC-1:0] oc_calm, oc_next;
    logic fault_any;
    assign oc_lost = ~oc_ok;
    assign fault_clr = (btn_sync & ~btn_prev_q) | sw_clr;
    assign fault_any = (|flt_q.oc) | flt_q.ov;
    // Flashing input reads healthy on alternate samples; clear needs two
    genvar g;
    generate
        for (g = 0; g < NUM_OC; g++)
        begin : g_oc
            assign oc_calm[g] = oc_ok[g] & oc_ok_prev_q[g];
            assign oc_next[g] = oc_lost[g] |
                (flt_q.oc[g] & ~(fault_clr & oc_calm[g]));
        end
    endgenerate
    always_comb
    begin
        flt_d.oc = oc_next;
        flt_d.ov = ov_sync | (flt_q.ov & ~fault_clr);
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            btn_prev_q <= 1'b0;
            oc_ok_prev_q <= SY_RST[NUM_OC-1:0];
            flt_q <= '0;
        end
        else
        begin
            btn_prev_q <= btn_sync;
            oc_ok_prev_q <= oc_ok;
            flt_q <= flt_d;
        end
    end
    assign overcurrent_ind = flt_q.oc;
    assign overvoltage_ind = flt_q.ov;
    ////////////////////////////////////////////////////////////////////////
    // Drive gating and outputs
    bsd_drive_t drv_q, drv_d;
    assign gate_ok = ~fault_any & duty_sync;
    always_comb
    begin
        drv_d.a_hi = phase_q & gate_ok;
        drv_d.a_lo = phase_q & gate_ok;
        drv_d.b_hi = ~phase_q & gate_ok;
        drv_d.b_lo = ~phase_q & gate_ok;
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            drv_q <= '0;
        else
            drv_q <= drv_d;
    end
    assign switch_drive_a_hi = drv_q.a_hi;
    assign switch_drive_a_lo = drv_q.a_lo;
    assign switch_drive_b_hi = drv_q.b_hi;
    assign switch_drive_b_lo = drv_q.b_lo;
    ////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky latch events, write-one-to-clear
    logic [NUM_EV-1:0] ev, ev_clr;
    assign ev = {flt_d.ov & ~flt_q.ov, flt_d.oc & ~flt_q.oc};
    assign ev_clr = (wr_go && avs_byteenable[0] && avs_address == REG_IRQ_CLR)
        ? avs_writedata[NUM_EV-1:0] : '0;
    always_comb
    begin
        irq_st_d = ev | (irq_st_q & ~ev_clr);
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_st_q <= '0;
        else
            irq_st_q <= irq_st_d;
    end
    assign irq = |(irq_st_q & irq_en_q);
    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_tick_gap;
        ##1 !tick [*8];
    endsequence
    property p_osc_tick;
        tick |-> s_tick_gap ##17 tick;
    endproperty
    a_osc_tick: assert property (p_osc_tick)
        else $error("oscillator tick spacing wrong");
    sequence s_half_end;
        sel_q != BSD_SEL_RUN && half_end;
    endsequence
    property p_test_toggle;
        s_half_end |=> phase_q != $past(phase_q) && cnt_q == '0;
    endproperty
    a_test_toggle: assert property (p_test_toggle)
        else $error("test drive did not toggle at half period");
    property p_pairs;
        drv_q.a_hi == drv_q.a_lo && drv_q.b_hi == drv_q.b_lo
            && !(drv_q.a_hi && drv_q.b_hi);
    endproperty
    a_pairs: assert property (p_pairs)
        else $error("drive pairs not in antiphase");
    property p_run_follow;
        sel_q == BSD_SEL_RUN && sel_d == BSD_SEL_RUN |=>
            phase_q == $past(ext_sync);
    endproperty
    a_run_follow: assert property (p_run_follow)
        else $error("run drive does not follow external input");
    property p_oc_set;
        |oc_lost |=> (flt_q.oc & $past(oc_lost)) == $past(oc_lost);
    endproperty
    a_oc_set: assert property (p_oc_set)
        else $error("lost overcurrent light not latched");
    property p_oc_clear;
        fault_clr && oc_calm == 4'hf |=> flt_q.oc == 4'h0;
    endproperty
    a_oc_clear: assert property (p_oc_clear)
        else $error("healthy overcurrent latch not cleared");
    property p_ov_hold;
        ov_sync || (flt_q.ov && !fault_clr) |=> flt_q.ov && overvoltage_ind;
    endproperty
    a_ov_hold: assert property (p_ov_hold)
        else $error("overvoltage latch dropped");
    property p_block;
        fault_any || !duty_sync |=> !switch_drive_a_hi && !switch_drive_b_hi;
    endproperty
    a_block: assert property (p_block)
        else $error("drive passed while blocked");
endmodule

// ==== tb/bsd_far_model.sv ====
// Gate-driver protection lights and external drive transmitter model
module bsd_far_model
    import bsd_pkg::*;
#(
    parameter int EXT_HALF = 60
)
(
    input wire logic core_clk,
    input wire logic [NUM_OC-1:0] oc_fault,
    input wire logic ext_on,
    output logic [NUM_OC-1:0] prot_light,
    output logic ext_light
);
    logic flash_q = 1'b0;
    logic ext_q = 1'b0;
    int ext_cnt = 0;

    ////////////////////////////////////////////////////////////////////////
    // Healthy light holds on; a faulted module flashes every cycle
    always_ff @(posedge core_clk)
    begin
        flash_q <= ~flash_q;
    end
    assign prot_light = ~oc_fault | {NUM_OC{flash_q}};

    ////////////////////////////////////////////////////////////////////////
    // Drive light alternates while on, stands dark otherwise
    always_ff @(posedge core_clk)
    begin
        if (!ext_on)
        begin
            ext_cnt <= 0;
            ext_q <= 1'b0;
        end
        else if (ext_cnt == EXT_HALF - 1)
        begin
            ext_cnt <= 0;
            ext_q <= ~ext_q;
        end
        else
        begin
            ext_cnt <= ext_cnt + 1;
        end
    end
    assign ext_light = ext_q;
endmodule

// ==== tb/bridge_switch_drive_control_tb.sv ====
// Self-checking bench for the bridge switch drive control block
module bridge_switch_drive_control_tb
    import bsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Short half periods keep the slow test rates cheap to simulate
    localparam int HS = 8;
    localparam int HM = 4;
    localparam int EH = 60;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic ov = 1'b0;
    logic duty = 1'b0;
    logic btn = 1'b0;
    logic ext_on = 1'b0;
    logic [NUM_OC-1:0] oc_fault = '0;
    logic [NUM_OC-1:0] prot;
    logic ext_light;
    logic [3:0] be = 4'hf;
    wire bsd_drive_t drv;
    logic [NUM_OC-1:0] oc_ind;
    logic ov_ind;
    logic irq;
    logic [31:0] r;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    always #20 core_clk = ~core_clk;

    bsd_drive_ctrl #(.HALF_SLOW_P(HS), .HALF_MID_P(HM)) dut (
        .core_clk(core_clk), .reset_n(reset_n),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_req),
        .overcurrent_input_1(prot[0]), .overcurrent_input_2(prot[1]),
        .overcurrent_input_3(prot[2]), .overcurrent_input_4(prot[3]),
        .overvoltage_input(ov), .ext_drive_input(ext_light),
        .duty_enable_input(duty), .fault_reset_button(btn),
        .switch_drive_a_hi(drv.a_hi), .switch_drive_a_lo(drv.a_lo),
        .switch_drive_b_hi(drv.b_hi), .switch_drive_b_lo(drv.b_lo),
        .overcurrent_ind(oc_ind), .overvoltage_ind(ov_ind), .irq(irq));

    bsd_far_model #(.EXT_HALF(EH)) far (
        .core_clk(core_clk), .oc_fault(oc_fault), .ext_on(ext_on),
        .prot_light(prot), .ext_light(ext_light));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic we, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= ~we;
        wr <= we;
        wdata <= d;
        @(posedge core_clk);
        while (wait_req !== 1'b0)
            @(posedge core_clk);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic pulse_btn();
        btn <= 1'b1;
        repeat (4) @(posedge core_clk);
        btn <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        bus(0, REG_CTRL, 0);
        check("ctrl", r, 32'h1);
        bus(0, REG_STATUS, 0);
        check("status", r & 32'h1f9f, 32'h0f80);
        bus(0, REG_IRQ_STAT, 0);
        check("irq stat", r, 0);
        bus(1, 5'h14, 32'hffffffff);
        bus(0, 5'h14, 0);
        check("unmapped", r, 0);
        bus(0, REG_CTRL, 0);
        check("ctrl kept", r, 32'h1);
        bus(0, REG_IRQ_EN, 0);
        check("irq en", r, 0);
        bus(1, REG_IRQ_EN, 32'h1f);
        bus(0, REG_IRQ_EN, 0);
        check("irq en wr", r, 32'h1f);
        be <= 4'he;
        bus(1, REG_IRQ_EN, 32'h0);
        be <= 4'hf;
        bus(0, REG_IRQ_EN, 0);
        check("lane off", r, 32'h1f);
    endtask

    // Measures one full high half of pair A, checking pairing throughout
    task automatic test_rate(input logic [1:0] sel, input int half);
        int n = 0;
        logic bad = 1'b0;
        bus(1, REG_CTRL, {30'h0, sel});
        while (drv.a_hi !== 1'b0)
            @(posedge core_clk);
        while (drv.a_hi !== 1'b1)
            @(posedge core_clk);
        do
        begin
            @(posedge core_clk);
            n++;
            if (drv.a_lo !== drv.a_hi || drv.b_hi !== ~drv.a_hi
                || drv.b_lo !== drv.b_hi)
                bad = 1'b1;
        end while (drv.a_hi === 1'b1);
        check("half period", n, half);
        check("antiphase", bad, 0);
    endtask

    task automatic test_oc();
        for (int ch = 0; ch < NUM_OC; ch++)
        begin
            oc_fault <= 4'(1 << ch);
            repeat (8) @(posedge core_clk);
            check("oc latch", oc_ind, 1 << ch);
            check("drive off", drv, 0);
            check("irq", irq, 1);
            bus(1, REG_CTRL, 32'h7);
            repeat (4) @(posedge core_clk);
            check("oc dark", oc_ind, 1 << ch);
            oc_fault <= '0;
            repeat (8) @(posedge core_clk);
            check("oc held", oc_ind, 1 << ch);
            pulse_btn();
            check("oc clear", oc_ind, 0);
            check("drive back", drv.a_hi ^ drv.b_hi, 1);
            bus(0, REG_IRQ_STAT, 0);
            check("irq stat", r, 1 << ch);
            bus(1, REG_IRQ_CLR, 32'h1f);
            repeat (2) @(posedge core_clk);
            check("irq clr", irq, 0);
        end
    endtask

    task automatic test_ov();
        ov <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("ov latch", {oc_ind, ov_ind}, 5'h01);
        check("drive off", drv, 0);
        bus(1, REG_IRQ_EN, 0);
        repeat (2) @(posedge core_clk);
        check("irq masked", irq, 0);
        bus(0, REG_IRQ_STAT, 0);
        check("irq stat", r, 32'h10);
        pulse_btn();
        check("ov persists", ov_ind, 1);
        ov <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("ov held", ov_ind, 1);
        bus(1, REG_CTRL, 32'h7);
        repeat (4) @(posedge core_clk);
        check("ov clear", ov_ind, 0);
        bus(1, REG_IRQ_CLR, 32'h10);
        bus(1, REG_IRQ_EN, 32'h1f);
        repeat (2) @(posedge core_clk);
        check("irq idle", irq, 0);
    endtask

    task automatic test_duty();
        duty <= 1'b0;
        repeat (6) @(posedge core_clk);
        check("duty gate", drv, 0);
        check("no fault", {oc_ind, ov_ind}, 0);
        duty <= 1'b1;
        repeat (6) @(posedge core_clk);
        check("duty pass", drv.a_hi ^ drv.b_hi, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        duty <= 1'b1;
        test_regs();
        $display("done: registers");
        test_rate(2'h1, HS * OSC_DIV);
        test_rate(2'h2, HM * OSC_DIV);
        ext_on <= 1'b1;
        test_rate(2'h0, EH);
        ext_on <= 1'b0;
        $display("done: slow, mid and run rates");
        test_rate(2'h3, HALF_FAST * OSC_DIV);
        $display("done: fast rate");
        test_oc();
        $display("done: overcurrent");
        test_ov();
        $display("done: overvoltage");
        test_duty();
        $display("done: duty enable");
        test_done();
    end

    // Longest path is the fast rate, about 25000 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            $display("unexpected run length: expected end, seen hang");
            test_done();
        end
    end
endmodule
